/* src/led_fault_protection_sequencer.sv */
// Operation
// - Standby rise starts regulator; boost waits for PWM
// - Soft start begins on PWM rise, then continues
// - No gate pulses below 0.8 V soft start
// - Soft start ends at 4.0 V; detection enabled
// - Standby low stops gate, discharges soft start
// - Latch mode masks faults of four counts
// - Longer fault charges timer; PWM no longer gates
// - Latch mode fault cleared while charging discharges timer
// - Latch mode threshold stops channel, fault low
// - Stopped channel latched until standby, reset, clear
// - Retry mode fault low until charge plus timer
// - Retry mode masks four counts, then error high
// - Three more counts: error low, charge starts
// - Discharge timer three counts after threshold
// - 1024-count reset timer, then fault released
// - Persistent fault toggles error; discharge second fall
// - After reset timer, normal charge retries
// - Short detection off with single channel
// - Short needs three conditions over four counts
// - Counting runs at boost oscillator rate
`default_nettype none
module led_fault_protection_sequencer #(
  parameter int unsigned NCH = ledseq_pkg::NUM_CH,
  parameter int unsigned DIV = ledseq_pkg::OSC_DIV
) (
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           standby_control,
  input  wire logic           fail_mode,
  input  wire logic           fault_reset,
  input  wire logic           fault_latch_clear_bit,
  input  wire logic [NCH-1:0] pwm_dim,
  input  wire logic [NCH-1:0] channel_enable,
  input  wire logic           ss_above_low,
  input  wire logic           ss_above_high,
  input  wire logic           cp_at_threshold,
  input  wire logic [NCH-1:0] led_open,
  input  wire logic [NCH-1:0] led_above_short,
  input  wire logic [NCH-1:0] led_at_or_below_low,
  input  wire logic           boost_pwm_raw,
  output logic                regulator_enable,
  output logic                ss_charge,
  output logic                ss_discharge,
  output logic                boost_gate,
  output logic                fault_detect_enable,
  output logic                cp_charge,
  output logic                cp_discharge,
  output logic                fail_out,
  output logic                fail_oe,
  output logic                err_flag,
  output logic [NCH-1:0]      channel_stop
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Local names for the package state codes
  localparam ledseq_pkg::seq_state_t SQ_OFF   = ledseq_pkg::SQ_OFF;
  localparam ledseq_pkg::seq_state_t SQ_WAIT  = ledseq_pkg::SQ_WAIT;
  localparam ledseq_pkg::seq_state_t SQ_SOFT  = ledseq_pkg::SQ_SOFT;
  localparam ledseq_pkg::seq_state_t SQ_RUN   = ledseq_pkg::SQ_RUN;
  localparam ledseq_pkg::flt_state_t F_IDLE   = ledseq_pkg::F_IDLE;
  localparam ledseq_pkg::flt_state_t F_ERR    = ledseq_pkg::F_ERR;
  localparam ledseq_pkg::flt_state_t F_CHARGE = ledseq_pkg::F_CHARGE;
  localparam ledseq_pkg::flt_state_t F_HOLD   = ledseq_pkg::F_HOLD;
  localparam ledseq_pkg::flt_state_t F_RESET  = ledseq_pkg::F_RESET;
  localparam ledseq_pkg::flt_state_t F_LATCH  = ledseq_pkg::F_LATCH;

  // ------------------------------------------------------------------
  // Count enable and short detection
  // ------------------------------------------------------------------
  ledseq_if u_link ();

  osc_tick_gen #(.DIV(DIV)) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .link  (u_link.div)
  );

  short_qualify #(.NCH(NCH)) u_short (
    .clock               (clock),
    .rst_n               (rst_n),
    .pwm_dim             (pwm_dim),
    .led_above_short     (led_above_short),
    .led_at_or_below_low (led_at_or_below_low),
    .channel_enable      (channel_enable),
    .link                (u_link.det)
  );

  logic           tick;        // One oscillator count
  logic [NCH-1:0] fault_vec;   // Faulty channels
  logic           fault_any;   // Any fault present
  logic           pwm_any;     // Any PWM high

  // comparator bits taken as synchronous levels
  assign tick      = u_link.tick;
  assign fault_vec = (led_open | u_link.short_hit) & channel_enable;
  assign fault_any = |fault_vec;
  assign pwm_any   = |pwm_dim;

  // ------------------------------------------------------------------
  // Start-up sequencer
  // ------------------------------------------------------------------
  ledseq_pkg::seq_state_t seq_r;     // Sequencer state
  ledseq_pkg::seq_state_t seq_nxt;
  logic                   stb_prev_r; // Standby last cycle
  logic                   pwm_prev_r; // PWM last cycle
  logic                   pwm_rise;   // PWM low to high

  assign pwm_rise = pwm_any && !pwm_prev_r;

  // Next sequencer state
  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      SQ_OFF:  if (standby_control && !stb_prev_r) seq_nxt = SQ_WAIT;
      SQ_WAIT: if (pwm_rise) seq_nxt = SQ_SOFT;
      // top of soft start ends interval
      SQ_SOFT: if (ss_above_high) seq_nxt = SQ_RUN;
      SQ_RUN:  seq_nxt = SQ_RUN;
    endcase
    if (!standby_control) seq_nxt = SQ_OFF;
  end

  // Register sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seq_r      <= SQ_OFF;
      stb_prev_r <= 1'b0;
      pwm_prev_r <= 1'b0;
    end else begin
      seq_r      <= seq_nxt;
      stb_prev_r <= standby_control;
      pwm_prev_r <= pwm_any;
    end
  end

  // Sequencer outputs; gate stays combinational so standby acts at once
  assign regulator_enable    = (seq_r != SQ_OFF);
  assign ss_charge           = standby_control &&
                               (seq_r == SQ_SOFT || seq_r == SQ_RUN);
  assign ss_discharge        = !standby_control || seq_r == SQ_OFF ||
                               seq_r == SQ_WAIT;
  assign fault_detect_enable = (seq_r == SQ_RUN);
  assign boost_gate = boost_pwm_raw && standby_control && ss_above_low &&
                      (seq_r == SQ_SOFT || seq_r == SQ_RUN);

  // ------------------------------------------------------------------
  // Fault timer controller
  // ------------------------------------------------------------------
  ledseq_pkg::flt_state_t flt_r;     // Fault state
  ledseq_pkg::flt_state_t flt_nxt;
  logic [10:0]    cnt_r;             // Shared count
  logic [10:0]    cnt_nxt;
  logic           err_r;             // Internal error flag
  logic           err_nxt;
  logic [1:0]     falls_r;           // Error falling edges seen
  logic [1:0]     falls_nxt;
  logic           retry_r;           // Charge again after reset timer
  logic           retry_nxt;
  logic           fail_r;            // Fault output driven low
  logic           fail_nxt;
  logic [NCH-1:0] stop_r;            // Latched-off channels
  logic [NCH-1:0] stop_nxt;

  // Next fault state
  always_comb begin
    flt_nxt   = flt_r;
    cnt_nxt   = cnt_r;
    err_nxt   = err_r;
    falls_nxt = falls_r;
    retry_nxt = retry_r;
    fail_nxt  = fail_r;
    stop_nxt  = stop_r;
    unique case (flt_r)
      // Count PWM-high fault time
      F_IDLE: if (tick) begin
        if (!fault_any) begin
          cnt_nxt = 11'h000;
        end else if (pwm_any) begin
          // four counts or fewer stay masked
          if (cnt_r == 11'(ledseq_pkg::MASK_CNT)) begin
            cnt_nxt = 11'h000;
            if (fail_mode) begin
              flt_nxt = F_ERR;
              err_nxt = 1'b1;
            end else begin
              flt_nxt = F_CHARGE;
            end
          end else begin
            cnt_nxt = cnt_r + 11'h001;
          end
        end
      end
      // Error flag high for three counts
      F_ERR: if (tick) begin
        if (!fault_any) begin
          flt_nxt = F_IDLE;
          err_nxt = 1'b0;
          cnt_nxt = 11'h000;
        end else if (cnt_r == 11'(ledseq_pkg::ERR_CNT - 3'h1)) begin
          flt_nxt   = F_CHARGE;
          err_nxt   = 1'b0;
          fail_nxt  = 1'b1;
          falls_nxt = 2'h0;
          retry_nxt = 1'b0;
          cnt_nxt   = 11'h000;
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      // Fault timer charging
      F_CHARGE: if (!fail_mode) begin
        if (tick && !fault_any) begin
          flt_nxt = F_IDLE;
          cnt_nxt = 11'h000;
        end else if (cp_at_threshold) begin
          flt_nxt  = F_LATCH;
          fail_nxt = 1'b1;
          stop_nxt = stop_r | fault_vec;
        end
      end else begin
        if (cp_at_threshold) begin
          flt_nxt = F_HOLD;
          err_nxt = 1'b0;
          cnt_nxt = 11'h000;
        end else if (tick && fault_any) begin
          err_nxt = !err_r;
          if (err_r) begin
            falls_nxt = falls_r + 2'h1;
            if (falls_r == ledseq_pkg::ERR_FALLS - 2'h1) begin
              flt_nxt   = F_RESET;
              retry_nxt = 1'b1;
              cnt_nxt   = 11'h000;
            end
          end
        end else if (tick) begin
          err_nxt = 1'b0;
        end
      end
      F_HOLD: if (tick) begin
        if (cnt_r == 11'(ledseq_pkg::HOLD_CNT - 3'h1)) begin
          flt_nxt = F_RESET;
          cnt_nxt = 11'h000;
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      // reset timer with output held low
      F_RESET: if (tick) begin
        if (cnt_r == ledseq_pkg::RST_CNT - 11'h001) begin
          cnt_nxt = 11'h000;
          if (retry_r || fault_any) begin
            flt_nxt   = F_CHARGE;
            retry_nxt = 1'b0;
            falls_nxt = 2'h0;
          end else begin
            flt_nxt  = F_IDLE;
            fail_nxt = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      F_LATCH: if (fault_reset || fault_latch_clear_bit) begin
        flt_nxt  = F_IDLE;
        fail_nxt = 1'b0;
        stop_nxt = '0;
        cnt_nxt  = 11'h000;
      end
      default: flt_nxt = F_IDLE;
    endcase
    // standby low or no detection clears all
    if (!standby_control || seq_r != SQ_RUN) begin
      flt_nxt   = F_IDLE;
      cnt_nxt   = 11'h000;
      err_nxt   = 1'b0;
      falls_nxt = 2'h0;
      retry_nxt = 1'b0;
      fail_nxt  = 1'b0;
      stop_nxt  = '0;
    end
  end

  // Register fault controller
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flt_r   <= F_IDLE;
      cnt_r   <= 11'h000;
      err_r   <= 1'b0;
      falls_r <= 2'h0;
      retry_r <= 1'b0;
      fail_r  <= 1'b0;
      stop_r  <= '0;
    end else begin
      flt_r   <= flt_nxt;
      cnt_r   <= cnt_nxt;
      err_r   <= err_nxt;
      falls_r <= falls_nxt;
      retry_r <= retry_nxt;
      fail_r  <= fail_nxt;
      stop_r  <= stop_nxt;
    end
  end

  // Fault outputs; fault pin is open drain, pulled low only
  assign cp_charge    = (flt_r == F_CHARGE || flt_r == F_HOLD);
  assign cp_discharge = !cp_charge;
  assign fail_out     = 1'b0;
  assign fail_oe      = fail_r;
  assign err_flag     = err_r;
  assign channel_stop = stop_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_reset_entry;
    flt_r != F_RESET ##1 flt_r == F_RESET;
  endsequence

  chk_gate_standby: assert property (!standby_control |-> !boost_gate)
    else $error("gate active with standby low");
  chk_gate_ss_low: assert property (!ss_above_low |-> !boost_gate)
    else $error("gate active below soft start level");
  chk_wait_pwm: assert property (seq_r == SQ_WAIT && !pwm_rise &&
    standby_control |=> seq_r == SQ_WAIT && !ss_charge)
    else $error("soft start without PWM edge");
  chk_soft_hold: assert property (seq_r == SQ_SOFT && standby_control &&
    !ss_above_high |=> ss_charge)
    else $error("soft start charge interrupted");
  chk_detect_on: assert property (seq_r == SQ_SOFT && standby_control &&
    ss_above_high |=> fault_detect_enable)
    else $error("detection not enabled at soft start end");
  chk_latch_hold: assert property (flt_r == F_LATCH && standby_control &&
    !fault_reset && !fault_latch_clear_bit |=> flt_r == F_LATCH && fail_oe)
    else $error("latched fault released");
  chk_latch_stop: assert property (!fail_mode && flt_r == F_CHARGE &&
    cp_at_threshold && fault_any && fault_detect_enable && standby_control
    |=> fail_oe && channel_stop != '0)
    else $error("threshold did not stop channel");
  chk_charge_drop: assert property (!fail_mode && flt_r == F_CHARGE &&
    tick && !fault_any && standby_control |=> !cp_charge)
    else $error("timer kept charging after fault cleared");
  chk_reset_hold: assert property (s_reset_entry |->
    (fail_oe && !cp_charge)[*8])
    else $error("reset timer released output early");
  chk_err_to_charge: assert property (flt_r == F_ERR && tick && fault_any &&
    cnt_r == 11'h002 && fault_detect_enable && standby_control
    |=> !err_flag && fail_oe && cp_charge)
    else $error("error phase did not start charge");
endmodule
`default_nettype wire

/* shared/ledseq_pkg.sv */
`default_nettype none
package ledseq_pkg;
  // ------------------------------------------------------------------
  // Clocking
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 10_000_000;   // System clock rate
  localparam int unsigned OSC_HZ  = 200_000;      // Boost oscillator rate
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ; // Clocks per count

  // ------------------------------------------------------------------
  // Channel count and fault counts (oscillator counts)
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH   = 6;          // LED channels
  localparam logic [2:0]  MASK_CNT = 3'h4;       // Masked PWM-high counts
  localparam logic [2:0]  ERR_CNT  = 3'h3;       // Error flag high counts
  localparam logic [2:0]  HOLD_CNT = 3'h3;       // Threshold to discharge
  localparam logic [10:0] RST_CNT  = 11'h400;    // Reset timer, 1024
  localparam logic [2:0]  SHORT_CNT = 3'h4;      // Short qualify counts
  localparam logic [1:0]  ERR_FALLS = 2'h2;      // Falls before discharge

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {SQ_OFF, SQ_WAIT, SQ_SOFT, SQ_RUN} seq_state_t;
  typedef enum logic [2:0] {
    F_IDLE, F_ERR, F_CHARGE, F_HOLD, F_RESET, F_LATCH
  } flt_state_t;
endpackage
`default_nettype wire

/* shared/ledseq_if.sv */
`default_nettype none
// Oscillator count enable and qualified short flags
interface ledseq_if;
  logic                            tick;      // One-cycle count enable
  logic [ledseq_pkg::NUM_CH-1:0]   short_hit; // Qualified short per channel
  modport div (output tick);
  modport det (input tick, output short_hit);
  modport top (input tick, input short_hit);
endinterface
`default_nettype wire

/* src/osc_tick_gen.sv */
`default_nettype none
// ----------------------------------------------------------------------
// Divider giving one enable pulse per boost oscillator period
// ----------------------------------------------------------------------
module osc_tick_gen #(
  parameter int unsigned DIV = ledseq_pkg::OSC_DIV
) (
  input  wire logic clock,
  input  wire logic rst_n,
  ledseq_if.div     link
);
  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_r;    // Divider count
  logic [W-1:0] div_nxt;
  logic         tick_r;   // Registered enable
  logic         tick_nxt;

  // Next divider value, pulse at wrap
  always_comb begin
    tick_nxt = (div_r == LAST);
    div_nxt  = tick_nxt ? '0 : div_r + W'(1);
  end

  // Register divider
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign link.tick = tick_r;
endmodule
`default_nettype wire

/* src/short_qualify.sv */
`default_nettype none
// ----------------------------------------------------------------------
// Per-channel LED short qualification
// ----------------------------------------------------------------------
module short_qualify #(
  parameter int unsigned NCH = ledseq_pkg::NUM_CH
) (
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic [NCH-1:0] pwm_dim,
  input  wire logic [NCH-1:0] led_above_short,
  input  wire logic [NCH-1:0] led_at_or_below_low,
  input  wire logic [NCH-1:0] channel_enable,
  ledseq_if.det               link
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Number of set bits
  function automatic int unsigned ones(input logic [NCH-1:0] v);
    int unsigned n;
    n = 0;
    for (int i = 0; i < NCH; i++) n += v[i];
    return n;
  endfunction

  logic [2:0]     cnt_r [NCH];   // Qualify counters
  logic [2:0]     cnt_nxt [NCH];
  logic [NCH-1:0] hit_r;         // Qualified shorts
  logic [NCH-1:0] hit_nxt;
  logic           multi;         // More than one channel driven
  logic [NCH-1:0] low_on;        // PWM-high channels at or below 3 V

  assign multi  = (ones(channel_enable) > 1);
  assign low_on = pwm_dim & led_at_or_below_low;

  // Count conditions held on each oscillator count
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cnt_nxt[i] = cnt_r[i];
      hit_nxt[i] = hit_r[i];
      if (!multi) begin
        cnt_nxt[i] = 3'h0;
        hit_nxt[i] = 1'b0;
      end else if (pwm_dim[i] && led_above_short[i] &&
                   |(low_on & ~(NCH'(1) << i))) begin
        if (link.tick) begin
          if (cnt_r[i] == ledseq_pkg::SHORT_CNT) begin
            hit_nxt[i] = 1'b1;           // Held beyond 4 counts
          end else begin
            cnt_nxt[i] = cnt_r[i] + 3'h1;
          end
        end
      end else begin
        cnt_nxt[i] = 3'h0;               // Condition broken
        hit_nxt[i] = 1'b0;
      end
    end
  end

  // Register counters and flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) cnt_r[i] <= 3'h0;
      hit_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) cnt_r[i] <= cnt_nxt[i];
      hit_r <= hit_nxt;
    end
  end

  assign link.short_hit = hit_r;

  chk_short_single: assert property (!multi |=> hit_r == '0)
    else $error("short flagged with one channel driven");
endmodule
`default_nettype wire

/* tb/analog_node_model.sv */
`default_nettype none
// Soft-start and fault-timer nodes seen as comparator bits
module analog_node_model #(
  parameter int SS_LO = 10,  // Cycles to the low soft-start level
  parameter int SS_HI = 30,  // Cycles to the high soft-start level
  parameter int CP_TH = 40   // Cycles to the fault-timer threshold
) (
  input  wire logic clock,
  input  wire logic ss_charge,
  input  wire logic ss_discharge,
  input  wire logic cp_charge,
  input  wire logic cp_discharge,
  output var logic  ss_above_low = 1'b0,
  output var logic  ss_above_high = 1'b0,
  output var logic  cp_at_threshold = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int ss_lvl = 0;  // Soft-start charge level
  int cp_lvl = 0;  // Fault-timer charge level
  // ------------------------------------------------------------
  // Node charge, saturating at the top level
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (ss_discharge === 1'b1) begin
      ss_lvl <= 0;
    end else if (ss_charge === 1'b1 && ss_lvl < SS_HI) begin
      ss_lvl <= ss_lvl + 1;
    end
    if (cp_discharge === 1'b1) begin
      cp_lvl <= 0;
    end else if (cp_charge === 1'b1 && cp_lvl < CP_TH) begin
      cp_lvl <= cp_lvl + 1;
    end
  end
  always @(posedge clock) begin
    ss_above_low    <= (ss_lvl >= SS_LO);
    ss_above_high   <= (ss_lvl >= SS_HI);
    cp_at_threshold <= (cp_lvl >= CP_TH);
  end
endmodule
`default_nettype wire

/* tb/led_fault_protection_sequencer_bench.sv */
`default_nettype none
module led_fault_protection_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CP_TH = 40;      // Fault-timer charge cycles
  logic       clock = 1'b0;       // 10 MHz clock
  logic       rst_n = 1'b0;       // Synchronous reset
  logic       standby_control = 1'b0, fail_mode = 1'b0;
  logic       fault_reset = 1'b0, clr_bit = 1'b0, boost_pwm_raw = 1'b0;
  logic [5:0] pwm_dim = 6'h00, channel_enable = 6'h3F, led_open = 6'h00;
  logic [5:0] led_above_short = 6'h00, led_at_or_below_low = 6'h00;
  logic       regulator_enable, ss_charge, ss_discharge, boost_gate;
  logic       fault_detect_enable, cp_charge, cp_discharge, fail_out;
  logic       fail_oe, err_flag, ss_above_low, ss_above_high, cp_at_th;
  logic [5:0] channel_stop;       // Latched-off channels
  wire logic [5:0] mon;           // Watched outputs by index
  int         err_total = 0, checked = 0, cycles = 0, k;
  assign mon = {channel_stop[0], err_flag, fail_oe, cp_charge,
                fault_detect_enable, ss_charge};
  // ------------------------------------------------------------
  // Design, node model and clock
  // ------------------------------------------------------------
  led_fault_protection_sequencer #(.NCH(6), .DIV(2)) i_dut (
    .clock(clock), .rst_n(rst_n), .standby_control(standby_control),
    .fail_mode(fail_mode), .fault_reset(fault_reset),
    .fault_latch_clear_bit(clr_bit), .pwm_dim(pwm_dim),
    .channel_enable(channel_enable), .ss_above_low(ss_above_low),
    .ss_above_high(ss_above_high), .cp_at_threshold(cp_at_th),
    .led_open(led_open), .led_above_short(led_above_short),
    .led_at_or_below_low(led_at_or_below_low),
    .boost_pwm_raw(boost_pwm_raw), .regulator_enable(regulator_enable),
    .ss_charge(ss_charge), .ss_discharge(ss_discharge),
    .boost_gate(boost_gate), .fault_detect_enable(fault_detect_enable),
    .cp_charge(cp_charge), .cp_discharge(cp_discharge),
    .fail_out(fail_out), .fail_oe(fail_oe), .err_flag(err_flag),
    .channel_stop(channel_stop));
  analog_node_model #(.CP_TH(CP_TH)) i_nodes (
    .clock(clock), .ss_charge(ss_charge), .ss_discharge(ss_discharge),
    .cp_charge(cp_charge), .cp_discharge(cp_discharge),
    .ss_above_low(ss_above_low), .ss_above_high(ss_above_high),
    .cp_at_threshold(cp_at_th));
  always #50 clock = ~clock;
  // Hang guard on a cycle ceiling
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 12000) begin
      err_total++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait at most lim+1 cycles for a watched output to reach val
  task automatic wait_on(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    @(negedge clock);
    while (mon[idx] !== val && n < lim) begin
      @(negedge clock);
      n++;
    end
    check(mon[idx], val);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  // supplies are taken as settled before reset is released
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    @(negedge clock);
    check(ss_discharge, 1'b1);
    check(fail_oe, 1'b0);
    check(fail_out, 1'b0);
    @(posedge clock);
    standby_control <= 1'b1;
    boost_pwm_raw <= 1'b1;
    cyc(3);
    @(negedge clock);
    check(regulator_enable, 1'b1);
    check(boost_gate, 1'b0);
    @(posedge clock);
    pwm_dim <= 6'h3F;
    @(posedge clock);
    pwm_dim <= 6'h00;
    wait_on(0, 1'b1, 4);
    check(boost_gate, 1'b0);
    wait_on(1, 1'b1, 40);
    check(boost_gate, 1'b1);
    // Latch-off mode: short burst, then persistent fault
    @(posedge clock);
    pwm_dim <= 6'h01;
    led_open <= 6'h01;
    cyc(6);
    led_open <= 6'h00;
    wait_on(2, 1'b0, 20);
    cyc(19);
    @(negedge clock);
    check(cp_charge, 1'b0);
    @(posedge clock);
    led_open <= 6'h01;
    wait_on(2, 1'b1, 30);
    @(posedge clock);
    pwm_dim <= 6'h00;
    cyc(7);
    @(negedge clock);
    check(cp_charge, 1'b1);
    @(posedge clock);
    led_open <= 6'h00;
    wait_on(2, 1'b0, 8);
    @(posedge clock);
    pwm_dim <= 6'h01;
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      led_open <= 6'h01;
      wait_on(3, 1'b1, CP_TH + 40);
      check(channel_stop, 6'h01);
      @(posedge clock);
      led_open <= 6'h00;
      cyc(9);
      @(negedge clock);
      check(channel_stop, 6'h01);
      @(posedge clock);
      if (k == 0) begin
        clr_bit <= 1'b1;
      end else begin
        fault_reset <= 1'b1;
      end
      @(posedge clock);
      clr_bit <= 1'b0;
      fault_reset <= 1'b0;
      wait_on(5, 1'b0, 4);
      check(fail_oe, 1'b0);
      check(cp_discharge, 1'b1);
    end
    // Short qualification, single channel and all six channels
    @(posedge clock);
    channel_enable <= 6'h01;
    pwm_dim <= 6'h03;
    led_above_short <= 6'h01;
    led_at_or_below_low <= 6'h02;
    cyc(29);
    @(negedge clock);
    check(cp_charge, 1'b0);
    @(posedge clock);
    channel_enable <= 6'h3F;
    wait_on(2, 1'b1, 30);
    @(posedge clock);
    led_above_short <= 6'h00;
    wait_on(2, 1'b0, 8);
    // Auto-retry mode, transient fault
    @(posedge clock);
    pwm_dim <= 6'h01;
    fail_mode <= 1'b1;
    led_open <= 6'h01;
    wait_on(4, 1'b1, 20);
    wait_on(4, 1'b0, 10);
    check(cp_charge, 1'b1);
    check(fail_oe, 1'b1);
    @(posedge clock);
    led_open <= 6'h00;
    wait_on(2, 1'b0, CP_TH + 20);
    cyc(2000);
    @(negedge clock);
    check(fail_oe, 1'b1);
    wait_on(3, 1'b0, 100);
    // Auto-retry mode, persistent fault
    @(posedge clock);
    led_open <= 6'h01;
    wait_on(2, 1'b1, 40);
    wait_on(2, 1'b0, 20);
    check(fail_oe, 1'b1);
    @(posedge clock);
    led_open <= 6'h00;
    wait_on(2, 1'b1, 2100);
    check(boost_gate, 1'b1);
    @(posedge clock);
    standby_control <= 1'b0;
    @(negedge clock);
    check(boost_gate, 1'b0);
    check(ss_discharge, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
